// ### design/codec_xfer_cfg.svh
// Constants for the transfer configuration and status block
`ifndef CODEC_XFER_CFG_SVH
`define CODEC_XFER_CFG_SVH
`define ADDR_IFACE_CFG     12'h000
`define ADDR_PIN_CTRL      12'h004
`define ADDR_ERR_STATUS    12'h008
`define ADDR_MODE_CTRL     12'h00C
`define ADDR_XFER_STATUS   12'h010
`define IFACE_CFG_RESET    8'h08
`define PIN_CTRL_RESET     8'h00
`define MODE_CTRL_RESET    8'h40
`define IFACE_EN_MASK      8'h03
`define CAL_NONE_FIRST     8'h28
`define CAL_CONV_LEN       8'h88
`define CAL_DAC_LEN        8'h28
`define CAL_FULL_LEN       8'hA8
`define SAMPLE_DIV         16'h1388
`define CENTER_SCALE       16'h0000
`define FMT_U8             3'h0
`define OVR_HALF           16'h6A12
`define OVR_FULL           17'h07FFF
`define DITHER_SEED        16'hACE1
`endif

// ### design/codec_xfer_pkg.sv
// Types for the transfer configuration and status block
package codec_xfer_pkg;
  typedef struct packed {
    logic       capture_pio_select;
    logic       playback_pio_select;
    logic       reserved;
    logic [1:0] calibration_type;
    logic       single_channel_mode;
    logic       capture_enable_bit;
    logic       playback_enable_bit;
  } iface_cfg_t;
  typedef struct packed {
    logic [1:0] external_control_pins;
    logic [2:0] reserved_hi;
    logic       dither_enable;
    logic       reserved_lo;
    logic       irq_pin_enable;
  } pin_ctrl_t;
  typedef struct packed {
    logic [15:0] left;
    logic [15:0] right;
  } sample_pair_t;
  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_RUN  = 2'b01
  } cal_state_t;
endpackage : codec_xfer_pkg

// ### design/codec_transfer_config_status.sv
// Transfer configuration, DMA routing, calibration and error status logic
`include "codec_xfer_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module codec_transfer_config_status
  import codec_xfer_pkg::*;
(
  input  wire logic               hclk,             // Clock
  input  wire logic               hresetn,          // Async reset, low
  input  wire logic               hsel,             // Slave select
  input  wire logic [11:0]        haddr,            // Byte address
  input  wire logic [1:0]         htrans,           // Transfer type
  input  wire logic               hwrite,           // Write when high
  input  wire logic [2:0]         hsize,            // Transfer size
  input  wire logic               hready,           // Bus ready in
  input  wire logic [31:0]        hwdata,           // Write data
  output logic [31:0]             hrdata,           // Read data
  output logic                    hreadyout,        // Always ready
  output logic                    hresp,            // Always OKAY
  input  wire logic               status_read,      // Status read strobe
  input  wire logic               int_flag,         // Status interrupt flag
  input  wire logic               playback_dma_ack, // Playback acknowledge
  input  wire logic               capture_dma_ack,  // Capture acknowledge
  input  wire logic               pio_play_write,   // Host wrote play sample
  input  wire logic               pio_cap_read,     // Host read capture sample
  input  wire logic [15:0]        play_data_in,     // Sample from host
  input  wire sample_pair_t       adc_sample,       // Raw converter sample
  output logic                    playback_dma_request, // Playback request pin
  output logic                    capture_dma_request,  // Capture request pin
  output logic                    play_pio_active,  // Playback PIO mode
  output logic                    cap_pio_active,   // Capture PIO mode
  output logic                    irq_pin,          // Interrupt pin
  output logic [1:0]              external_control_pins, // Control pins
  output logic [15:0]             dac_out,          // Sample to converters
  output logic [15:0]             cap_data_out,     // Held capture sample
  output logic                    calibration_in_progress // Calibrating
);

  iface_cfg_t  iface_reg;
  pin_ctrl_t   pin_reg;
  logic [7:0]  mode_reg;
  logic        mode_change_enable;
  logic        playback_mode_change_enable;
  logic        zero_on_underrun;
  logic [2:0]  capture_format;
  logic [1:0]  left_overrange;
  logic [1:0]  right_overrange;
  logic        playback_underrun;
  logic        capture_overrun;
  logic        summary_error;
  logic        request_status;
  logic        first_cal_reg;
  logic        mce_d_reg;
  cal_state_t  cal_state_reg;
  logic [7:0]  cal_len_reg;
  logic [7:0]  cal_cnt_reg;
  logic [15:0] div_reg;
  logic        tick;
  logic        cap_full_reg;
  logic [15:0] lfsr_reg;
  logic        wr_pend_reg;
  logic [11:0] addr_reg;
  logic        play_valid_reg;
  logic [15:0] play_hold_reg;
  logic        play_en;
  logic        cap_en;
  logic        play_dma;
  logic        cap_dma;
  logic        play_need;
  logic        cap_need;

  assign mode_change_enable          = mode_reg[6];
  assign playback_mode_change_enable = mode_reg[4];
  assign zero_on_underrun            = mode_reg[0];
  assign capture_format              = mode_reg[3:1];

  // Overrange classifier for one channel magnitude
  function automatic logic [1:0] ovr_code(input logic [15:0] s);
    logic [16:0] mag;
    mag = s[15] ? ({1'b0, ~s} + 17'h00001) : {1'b0, s};
    if (mag >= `OVR_FULL)
      ovr_code = 2'h2;
    else if (mag >= {1'b0, `OVR_HALF})
      ovr_code = 2'h1;
    else
      ovr_code = 2'h0;
  endfunction : ovr_code

  // Address phase that this slave must act on
  function automatic logic bus_access(input logic sel, input logic [1:0] trans,
                                      input logic rdy);
    bus_access = sel && trans[1] && rdy;
  endfunction : bus_access

  // Bus slave: zero wait, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Capture address phase of writes
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      addr_reg    <= 12'h000;
    end
    else if (hready)
    begin
      wr_pend_reg <= bus_access(hsel, htrans, hready) && hwrite && (hsize == 3'h2);
      addr_reg    <= haddr;
    end
  end

  // Interface configuration write with mode change gating
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      iface_reg <= `IFACE_CFG_RESET;
    else if (wr_pend_reg && addr_reg == `ADDR_IFACE_CFG)
    begin
      if (mode_change_enable || playback_mode_change_enable)
        iface_reg <= {hwdata[7:6], 1'b0, hwdata[4:0]};
      else
        iface_reg <= (iface_reg & ~`IFACE_EN_MASK) | (hwdata[7:0] & `IFACE_EN_MASK);
    end
  end

  // Pin control and mode control writes
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_reg  <= `PIN_CTRL_RESET;
      mode_reg <= `MODE_CTRL_RESET;
    end
    else if (wr_pend_reg)
    begin
      if (addr_reg == `ADDR_PIN_CTRL)
        pin_reg <= {hwdata[7:6], 3'h0, hwdata[2], 1'b0, hwdata[0]};
      if (addr_reg == `ADDR_MODE_CTRL)
      begin
        mode_reg[6] <= hwdata[6];
        mode_reg[4] <= hwdata[4];
        mode_reg[0] <= hwdata[0];
        if (hwdata[6] || hwdata[4] || mode_change_enable)
          mode_reg[3:1] <= hwdata[3:1];
      end
    end
  end

  // Read mux, registered for the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (bus_access(hsel, htrans, hready) && !hwrite)
    begin
      unique case (haddr)
        `ADDR_IFACE_CFG:   hrdata <= {24'h000000, iface_reg};
        `ADDR_PIN_CTRL:    hrdata <= {24'h000000, pin_reg};
        `ADDR_ERR_STATUS:  hrdata <= {24'h000000, capture_overrun, playback_underrun,
                                      calibration_in_progress, request_status,
                                      right_overrange, left_overrange};
        `ADDR_MODE_CTRL:   hrdata <= {24'h000000, mode_reg};
        `ADDR_XFER_STATUS: hrdata <= {31'h00000000, summary_error};
        default:           hrdata <= 32'h00000000;
      endcase
    end
  end

  // Sample period tick divider
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      div_reg <= 16'h0000;
    else if (tick)
      div_reg <= 16'h0000;
    else
      div_reg <= div_reg + 16'h0001;
  end
  assign tick = (div_reg == `SAMPLE_DIV - 16'h0001);

  // Calibration sequencer on mode change falling edge
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mce_d_reg     <= 1'b1;
      first_cal_reg <= 1'b1;
      cal_state_reg <= CAL_IDLE;
      cal_len_reg   <= 8'h00;
      cal_cnt_reg   <= 8'h00;
    end
    else
    begin
      mce_d_reg <= mode_change_enable;
      unique case (cal_state_reg)
        CAL_IDLE:
          if (mce_d_reg && !mode_change_enable)
          begin
            first_cal_reg <= 1'b0;
            cal_cnt_reg   <= 8'h00;
            unique case (iface_reg.calibration_type)
              2'h0: cal_len_reg <= first_cal_reg ? `CAL_NONE_FIRST : 8'h00;
              2'h1: cal_len_reg <= `CAL_CONV_LEN;
              2'h2: cal_len_reg <= `CAL_DAC_LEN;
              2'h3: cal_len_reg <= `CAL_FULL_LEN;
            endcase
            if (iface_reg.calibration_type != 2'h0 || first_cal_reg)
              cal_state_reg <= CAL_RUN;
          end
        CAL_RUN:
          if (tick)
          begin
            if (cal_cnt_reg == cal_len_reg - 8'h01)
              cal_state_reg <= CAL_IDLE;
            cal_cnt_reg <= cal_cnt_reg + 8'h01;
          end
        default:
          cal_state_reg <= CAL_IDLE;
      endcase
    end
  end
  assign calibration_in_progress = (cal_state_reg == CAL_RUN);

  // Transfer selection and DMA routing
  assign play_en  = iface_reg.playback_enable_bit;
  assign cap_en   = iface_reg.capture_enable_bit && !(iface_reg.single_channel_mode
                    && iface_reg.playback_enable_bit);
  assign play_dma = play_en && !iface_reg.playback_pio_select;
  assign cap_dma  = cap_en && !iface_reg.capture_pio_select;
  assign play_pio_active = play_en && iface_reg.playback_pio_select;
  assign cap_pio_active  = cap_en && iface_reg.capture_pio_select;
  assign play_need = play_dma && !play_valid_reg;
  assign cap_need  = cap_dma && cap_full_reg;
  assign playback_dma_request = play_need ||
                                (iface_reg.single_channel_mode && cap_need);
  assign capture_dma_request  = !iface_reg.single_channel_mode && cap_need;
  assign request_status = playback_dma_request || capture_dma_request;

  // Playback sample hand-off, latched while the strobe stands
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      play_valid_reg <= 1'b0;
      play_hold_reg  <= `CENTER_SCALE;
    end
    else if ((playback_dma_ack && play_dma) || (pio_play_write && play_pio_active))
    begin
      play_valid_reg <= 1'b1;
      play_hold_reg  <= play_data_in; // Data is only valid with the strobe
    end
    else if (tick && play_en)
      play_valid_reg <= 1'b0;
  end

  // Converter output, refreshed once per sample period while playback is enabled
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      dac_out <= `CENTER_SCALE;
    else if (tick && play_en)
    begin
      if (play_valid_reg)
        dac_out <= play_hold_reg;
      else if (zero_on_underrun)
        dac_out <= `CENTER_SCALE;
    end
  end

  // Underrun flag; a new error wins over a clearing read
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      playback_underrun <= 1'b0;
    else if (tick && play_en && !play_valid_reg)
      playback_underrun <= 1'b1;
    else if (status_read)
      playback_underrun <= 1'b0;
  end

  // Dither noise source, free running
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      lfsr_reg <= `DITHER_SEED;
    else
      lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
  end

  // Overrange codes, refreshed every sample period
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      left_overrange  <= 2'h0;
      right_overrange <= 2'h0;
    end
    else if (tick)
    begin
      left_overrange  <= ovr_code(adc_sample.left);
      right_overrange <= ovr_code(adc_sample.right);
    end
  end

  // Capture holding word; a full word is never overwritten
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cap_full_reg <= 1'b0;
      cap_data_out <= 16'h0000;
    end
    else if (tick && cap_en && !cap_full_reg)
    begin
      cap_full_reg <= 1'b1;
      if (pin_reg.dither_enable && capture_format == `FMT_U8)
        cap_data_out <= adc_sample.left + {8'h00, 1'b0, lfsr_reg[6:0]}
                        + {8'h00, 1'b0, lfsr_reg[14:8]} - 16'h0080;
      else
        cap_data_out <= adc_sample.left;
    end
    else if ((capture_dma_ack && cap_dma) || (pio_cap_read && cap_pio_active))
      cap_full_reg <= 1'b0;
  end

  // Overrun flag; a new error wins over a clearing read
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      capture_overrun <= 1'b0;
    else if (tick && cap_en && cap_full_reg)
      capture_overrun <= 1'b1;
    else if (status_read)
      capture_overrun <= 1'b0;
  end

  assign summary_error = capture_overrun || playback_underrun;

  // Interrupt and external control pins
  assign irq_pin = pin_reg.irq_pin_enable && int_flag;
  assign external_control_pins = pin_reg.external_control_pins;

endmodule : codec_transfer_config_status
`default_nettype wire

// ### tb/codec_xfer_sva.sv
// Port assertions for the transfer configuration block
`include "codec_xfer_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module codec_xfer_sva
(
  input wire logic        hclk,                   // Clock
  input wire logic        hresetn,                // Reset, low
  input wire logic        hsel,                   // Select
  input wire logic [11:0] haddr,                  // Address
  input wire logic [1:0]  htrans,                 // Transfer type
  input wire logic        hwrite,                 // Write
  input wire logic        hready,                 // Ready in
  input wire logic [31:0] hrdata,                 // Read data
  input wire logic        hreadyout,              // Ready out
  input wire logic        hresp,                  // Response
  input wire logic        int_flag,               // Status flag
  input wire logic        irq_pin,                // Interrupt pin
  input wire logic        playback_dma_request,   // Playback request
  input wire logic        capture_dma_request,    // Capture request
  input wire logic        cap_pio_active,         // Capture PIO
  input wire logic [1:0]  external_control_pins,  // Control pins
  input wire logic        calibration_in_progress // Calibrating
);
  wire logic acc   = hsel & htrans[1] & hready;
  wire logic rd_a  = acc & !hwrite;
  wire logic pin_a = acc & hwrite & (haddr == `ADDR_PIN_CTRL);
  logic      rd_q;
  logic      pin_q;
  logic      mode_q;
  // Address phases of the previous cycle
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      rd_q   <= 1'b0;
      pin_q  <= 1'b0;
      mode_q <= 1'b0;
    end
    else
    begin
      rd_q   <= rd_a;
      pin_q  <= pin_a;
      mode_q <= acc & hwrite & (haddr == `ADDR_MODE_CTRL);
    end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence cal_start;
    $rose(calibration_in_progress);
  endsequence
  sequence cal_hold;
    calibration_in_progress [*8];
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("slave not ready or not okay");
  a_irq_gate: assert property (irq_pin |-> int_flag)
    else $error("interrupt pin high without flag");
  a_cap_excl: assert property (cap_pio_active |-> !capture_dma_request)
    else $error("capture request while in PIO");
  a_cal_hold: assert property (cal_start |-> cal_hold)
    else $error("calibration ended too soon");
  a_cal_cause: assert property (cal_start |-> $past(mode_q) || $past(mode_q, 2) || $past(mode_q, 3))
    else $error("calibration without mode write");
  a_req_reset: assert property ($rose(hresetn) |-> !playback_dma_request && !capture_dma_request)
    else $error("request active after reset");
  a_rdata_hold: assert property (!rd_a && !rd_q |=> $stable(hrdata))
    else $error("read data changed without read");
  a_pins_hold: assert property (!pin_a && !pin_q |=> $stable(external_control_pins))
    else $error("control pins changed without write");
endmodule : codec_xfer_sva
`default_nettype wire

// ### tb/codec_host_model.sv
// Host and DMA controller model facing the transfer pins
`timescale 1ns/100ps
`default_nettype none
module codec_host_model
(
  input wire logic    hclk,                 // Clock
  input wire logic    hresetn,              // Reset, low
  input wire logic    slow,                 // Stall all answers
  input wire logic    playback_dma_request, // Playback request
  input wire logic    capture_dma_request,  // Capture request
  output logic        playback_dma_ack,     // Playback acknowledge
  output logic        capture_dma_ack,      // Capture acknowledge
  output logic [15:0] play_data_in          // Sample with acknowledge
);
  logic [3:0]  gap;
  logic [15:0] sample;
  // Answer standing requests every sixteen cycles; data toggles otherwise
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      gap              <= 4'h0;
      sample           <= 16'h0000;
      playback_dma_ack <= 1'b0;
      capture_dma_ack  <= 1'b0;
      play_data_in     <= 16'h0000;
    end
    else
    begin
      gap              <= gap + 4'h1;
      sample           <= sample + 16'h0123;
      playback_dma_ack <= !slow && playback_dma_request && (gap == 4'hF);
      capture_dma_ack  <= !slow && capture_dma_request && (gap == 4'h7);
      play_data_in     <= (gap == 4'hF) ? sample : ~play_data_in;
    end
endmodule : codec_host_model
`default_nettype wire

// ### tb/codec_transfer_config_status_test.sv
// Self-checking testbench for the transfer configuration block
`include "codec_xfer_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module codec_transfer_config_status_test;
  import codec_xfer_pkg::*;
  logic         hclk, hresetn, hsel, hwrite, status_read, int_flag, slow;
  logic         hreadyout, hresp, pdr, cdr, pack, cack, ppa, cpa, irq, cal;
  logic [11:0]  haddr;
  logic [1:0]   htrans, pins;
  logic [2:0]   hsize;
  logic [31:0]  hwdata, hrdata, rd, lfsr;
  logic [15:0]  play_data, dac_out, cap_data, cap_seen;
  logic [7:0]   cfg;
  logic [3:0]   exp;
  sample_pair_t adc_sample;
  int           fails, check_count;
  codec_transfer_config_status DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .status_read(status_read), .int_flag(int_flag), .playback_dma_ack(pack),
    .capture_dma_ack(cack), .pio_play_write(1'b0), .pio_cap_read(1'b0),
    .play_data_in(play_data), .adc_sample(adc_sample), .playback_dma_request(pdr),
    .capture_dma_request(cdr), .play_pio_active(ppa), .cap_pio_active(cpa), .irq_pin(irq),
    .external_control_pins(pins), .dac_out(dac_out), .cap_data_out(cap_data),
    .calibration_in_progress(cal));
  codec_host_model host (.hclk(hclk), .hresetn(hresetn), .slow(slow),
    .playback_dma_request(pdr), .capture_dma_request(cdr), .playback_dma_ack(pack),
    .capture_dma_ack(cack), .play_data_in(play_data));
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : next_rand
  // Expected {play request, capture request, play PIO, capture PIO}, host stalled
  function automatic logic [3:0] exp_io(input logic [7:0] c);
    logic pd, cd, ce;
    ce = c[1] & !(c[2] & c[0]);
    pd = c[0] & !c[6];
    cd = ce & !c[7];
    return {pd | (c[2] & cd), !c[2] & cd, c[0] & c[6], ce & c[7]};
  endfunction : exp_io
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want)
    begin
      fails++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check
  // One single-word transfer, held until ready
  task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    rd = hrdata;
  endtask : ahb
  task automatic rchk(input logic [11:0] a, input logic [31:0] mk, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    check(rd & mk, e);
  endtask : rchk
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  // Clock
  initial
  begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  // Random converter samples
  always @(posedge hclk)
  begin
    lfsr <= next_rand(lfsr);
    adc_sample <= lfsr;
  end
  // Watchdog
  initial
  begin
    repeat (35000) @(posedge hclk);
    fails++;
    end_sim();
  end
  // Main sequence
  initial
  begin
    {hresetn, hsel, hwrite, status_read, int_flag, slow} = 6'h01;
    {haddr, htrans, hwdata} = 46'h0;
    hsize = 3'h2;
    lfsr = 32'h0000D364;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    rchk(`ADDR_IFACE_CFG, 32'hDF, `IFACE_CFG_RESET);
    rchk(`ADDR_PIN_CTRL, 32'hFF, `PIN_CTRL_RESET);
    rchk(`ADDR_ERR_STATUS, 32'hFF, 32'h0);
    rchk(`ADDR_MODE_CTRL, 32'hFF, `MODE_CTRL_RESET);
    rchk(12'h020, 32'hFFFFFFFF, 32'h0);
    // Park one captured word; with the host stalled it stays full
    ahb(1'b1, `ADDR_IFACE_CFG, 32'h02);
    repeat (`SAMPLE_DIV) @(posedge hclk);
    cap_seen = cap_data;
    for (int i = 0; i < 17; i++)
    begin
      cfg = (i == 0) ? 8'h07 : (lfsr[7:0] & 8'hDF);
      ahb(1'b1, `ADDR_IFACE_CFG, {24'h0, cfg});
      rchk(`ADDR_IFACE_CFG, 32'hDF, {24'h0, cfg});
      exp = exp_io(cfg);
      check({28'h0, pdr, cdr, ppa, cpa}, {28'h0, exp});
      rchk(`ADDR_ERR_STATUS, 32'h10, {27'h0, exp[3] | exp[2], 4'h0});
    end
    ahb(1'b1, `ADDR_MODE_CTRL, 32'h0);
    repeat (3) @(posedge hclk);
    check({31'h0, cal}, 32'h1);
    ahb(1'b1, `ADDR_IFACE_CFG, 32'hFF);
    rchk(`ADDR_IFACE_CFG, 32'hDF, {24'h0, (cfg & 8'hDC) | 8'h03});
    rchk(`ADDR_ERR_STATUS, 32'h20, 32'h20);
    ahb(1'b1, `ADDR_MODE_CTRL, 32'h10);
    ahb(1'b1, `ADDR_IFACE_CFG, 32'h83);
    rchk(`ADDR_IFACE_CFG, 32'hDF, 32'h83);
    for (int i = 0; i < 4; i++)
    begin
      int_flag <= i[0];
      ahb(1'b1, `ADDR_PIN_CTRL, {24'h0, i[1:0], 6'h01});
      @(posedge hclk);
      check({30'h0, pins}, i);
      check({31'h0, irq}, {31'h0, int_flag});
    end
    int_flag <= 1'b1;
    ahb(1'b1, `ADDR_PIN_CTRL, 32'h0);
    @(posedge hclk);
    check({31'h0, irq}, 32'h0);
    slow <= 1'b1;
    repeat (11000) @(posedge hclk);
    rchk(`ADDR_ERR_STATUS, 32'hC0, 32'hC0);
    check({16'h0, cap_data}, {16'h0, cap_seen});
    rchk(`ADDR_XFER_STATUS, 32'h1, 32'h1);
    slow <= 1'b0;
    ahb(1'b1, `ADDR_IFACE_CFG, 32'h81);
    status_read <= 1'b1;
    @(posedge hclk);
    status_read <= 1'b0;
    rchk(`ADDR_ERR_STATUS, 32'hC0, 32'h0);
    rchk(`ADDR_XFER_STATUS, 32'h1, 32'h0);
    ahb(1'b1, `ADDR_MODE_CTRL, 32'h11);
    slow <= 1'b1;
    repeat (11000) @(posedge hclk);
    check({16'h0, dac_out}, {16'h0, `CENTER_SCALE});
    end_sim();
  end
endmodule : codec_transfer_config_status_test
bind codec_transfer_config_status codec_xfer_sva chk (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .int_flag(int_flag),
  .irq_pin(irq_pin), .playback_dma_request(playback_dma_request),
  .capture_dma_request(capture_dma_request), .cap_pio_active(cap_pio_active),
  .external_control_pins(external_control_pins),
  .calibration_in_progress(calibration_in_progress));
`default_nettype wire
